// ---- pkg/kpd_pkg.sv ----
package kpd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_KHZ   = 200000;
  localparam int unsigned T_SHOW_MS = 1000;
  localparam int unsigned T_IDLE_MS = 20000;
  localparam int unsigned T_HOLD_MS = 2000;
  localparam int unsigned T_DB_MS   = 10;
  localparam int unsigned SHOW_CYC  = T_SHOW_MS * CLK_KHZ;
  localparam int unsigned IDLE_CYC  = T_IDLE_MS * CLK_KHZ;
  localparam int unsigned HOLD_CYC  = T_HOLD_MS * CLK_KHZ;
  localparam int unsigned DB_CYC    = T_DB_MS * CLK_KHZ;
  // ----------------------------------------
  // Keys, limits, codes
  // ----------------------------------------
  localparam int K_MODE  = 0;
  localparam int K_SHIFT = 1;
  localparam int K_UP    = 2;
  localparam int K_DOWN  = 3;
  localparam int K_SET   = 4;
  localparam int NKEY    = 5;
  localparam int NDIG    = 5;
  localparam logic [4:0] MON_MAX = 5'h12;
  localparam logic [3:0] GRP_MAX = 4'h4;
  localparam logic [7:0] IDX_MAX = 8'h63;
  localparam logic [3:0] DEC_MAX = 4'h9;
  localparam logic [2:0] CUR_MAX = 3'h4;
  localparam logic [4:0] CH_A     = 5'h10;
  localparam logic [4:0] CH_L     = 5'h11;
  localparam logic [4:0] CH_P     = 5'h12;
  localparam logic [4:0] CH_DASH  = 5'h13;
  localparam logic [4:0] CH_BLANK = 5'h14;
  localparam logic [4:0] CH_C     = 5'h15;
  localparam logic [4:0] CH_R     = 5'h16;
  localparam logic [2:0] RES_SAVED = 3'h0;
  localparam logic [2:0] RES_RO    = 3'h1;
  localparam logic [2:0] RES_LOCK  = 3'h2;
  localparam logic [2:0] RES_RANGE = 3'h3;
  localparam logic [2:0] RES_SVON  = 3'h4;
  localparam logic [2:0] RES_RESTART = 3'h5;
  localparam int DP_LOW  = 0;
  localparam int DP_HIGH = 1;
  localparam int DP_NEG0 = 3;
  localparam int DP_NEG1 = 4;
  typedef enum logic [6:0] {
    ST_BOOT = 7'h01, ST_MON = 7'h02, ST_PAR = 7'h04, ST_SET = 7'h08,
    ST_WAIT = 7'h10, ST_RES = 7'h20, ST_FLT = 7'h40
  } mode_t;
endpackage

// ---- core/kpd_mode_ctrl.sv ----
`timescale 1ns/1ps
module kpd_mode_ctrl
  import kpd_pkg::*;
#(
  parameter int unsigned P_SHOW = SHOW_CYC,
  parameter int unsigned P_IDLE = IDLE_CYC,
  parameter int unsigned P_HOLD = HOLD_CYC,
  parameter int unsigned P_DB   = DB_CYC
)(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Raw keys, high while pressed
  input  wire logic [4:0]  key_raw,
  // Drive status
  input  wire logic        alarm_in,
  input  wire logic [11:0] fault_code,
  input  wire logic        diag_active,
  // Monitored value
  input  wire logic [31:0] val_bin,
  input  wire logic [39:0] val_bcd,
  input  wire logic        val_neg,
  input  wire logic        val_is32,
  // Selected parameter
  input  wire logic [19:0] par_bcd,
  input  wire logic        par_neg,
  input  wire logic        par_sign_ok,
  // Save handshake
  input  wire logic        save_done,
  input  wire logic [2:0]  save_result,
  output logic             save_req_q,
  output logic [19:0]      save_bcd_q,
  output logic             save_neg_q,
  output logic             diag_exec_q,
  // Selections
  output mode_t            st_q,
  output logic [4:0]       mon_sel_q,
  output logic [3:0]       grp_q,
  output logic [7:0]       idx_q,
  output logic             hex_q,
  output logic             half_q,
  // Display
  output logic [24:0]      disp_ch_q,
  output logic [4:0]       disp_dp_q,
  output logic [4:0]       disp_blink_q
);
  // ----------------------------------------
  // Key conditioning
  // ----------------------------------------
  logic [4:0] press;
  logic [4:0] lvl;
  genvar k;
  for (k = 0; k < NKEY; k++)
  begin : g_key
    logic        s1_q, s2_q, stab_q, pr_q;
    logic [31:0] cnt_q;
    wire         flip = (cnt_q == P_DB - 1);
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        s1_q   <= 1'b0;
        s2_q   <= 1'b0;
        stab_q <= 1'b0;
        pr_q   <= 1'b0;
        cnt_q  <= '0;
      end
      else
      begin
        s1_q   <= key_raw[k];
        s2_q   <= s1_q;
        // Bounce resets the count, so a press needs a quiet interval
        cnt_q  <= (s2_q == stab_q || flip) ? '0 : cnt_q + 32'h1;
        stab_q <= flip ? s2_q : stab_q;
        pr_q   <= flip && s2_q && !stab_q;
      end
    end
    assign press[k] = pr_q;
    assign lvl[k]   = stab_q;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] dig_step(input logic [3:0] d, input logic up);
    if (up)
      dig_step = (d >= DEC_MAX) ? 4'h0 : d + 4'h1;
    else
      dig_step = (d == 4'h0) ? DEC_MAX : d - 4'h1;
  endfunction

  function automatic logic [4:0] hx(input logic [3:0] d);
    hx = {1'b0, d};
  endfunction

  // ----------------------------------------
  // Mode sequencing
  // ----------------------------------------
  logic [31:0] tmr_q, idle_q, hold_q;
  logic        alarm_d1_q, sym_q, neg_q;
  logic [2:0]  cur_q, res_q;
  logic [19:0] edit_q;
  mode_t       st_d;

  wire p_mode = press[K_MODE];
  wire p_sh   = press[K_SHIFT];
  wire p_up   = press[K_UP];
  wire p_dn   = press[K_DOWN];
  wire p_set  = press[K_SET];
  wire tmr_done  = (tmr_q == 32'h0);
  wire alarm_new = alarm_in && !alarm_d1_q;
  wire idle_hit  = alarm_in && (idle_q == P_IDLE - 1)
                   && st_q != ST_FLT && st_q != ST_BOOT;
  wire ovr       = alarm_new || idle_hit;
  wire in_mon    = st_q == ST_MON;
  wire in_par    = st_q == ST_PAR;
  wire in_set    = st_q == ST_SET;
  wire hold_fire = in_set && lvl[K_SHIFT] && (hold_q == P_HOLD - 1);

  always_comb
  begin
    st_d = st_q;
    if (ovr)
      st_d = ST_FLT;
    else
      case (st_q)
        ST_BOOT: if (tmr_done) st_d = ST_MON;
        ST_MON:  if (p_mode) st_d = ST_PAR;
        ST_PAR:
        begin
          if (p_mode)
            st_d = ST_MON;
          else if (p_set)
            st_d = ST_SET;
        end
        ST_SET:
        begin
          if (p_mode)
            st_d = ST_PAR;
          else if (p_set && !diag_active)
            st_d = ST_WAIT;
        end
        ST_WAIT: if (save_done) st_d = ST_RES;
        ST_RES:  if (tmr_done) st_d = ST_PAR;
        ST_FLT:  if (p_mode) st_d = ST_MON;
        default: st_d = ST_MON;
      endcase
  end

  // Edited digits, one nibble per position
  logic [19:0] edit_nx;
  genvar i;
  for (i = 0; i < NDIG; i++)
  begin : g_dig
    assign edit_nx[4*i +: 4] = (in_set && cur_q == i && (p_up || p_dn))
                               ? dig_step(edit_q[4*i +: 4], p_up)
                               : edit_q[4*i +: 4];
  end

  wire load_tmr = (st_d == ST_RES && st_q != ST_RES)
                  || (in_mon && !ovr && (p_up || p_dn));

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q       <= ST_BOOT;
      tmr_q      <= P_SHOW - 1;
      alarm_d1_q <= 1'b0;
      idle_q     <= '0;
      hold_q     <= '0;
      sym_q      <= 1'b0;
    end
    else
    begin
      st_q       <= st_d;
      alarm_d1_q <= alarm_in;
      tmr_q      <= load_tmr ? P_SHOW - 1 : (tmr_done ? tmr_q : tmr_q - 32'h1);
      // Count quiet time only outside fault mode
      idle_q     <= (|press || st_q == ST_FLT) ? '0
                    : (idle_q == P_IDLE - 1 ? idle_q : idle_q + 32'h1);
      hold_q     <= (in_set && lvl[K_SHIFT])
                    ? (hold_q == P_HOLD ? hold_q : hold_q + 32'h1) : '0;
      sym_q      <= (in_mon && (p_up || p_dn)) ? 1'b1 : (tmr_done ? 1'b0 : sym_q);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_sel_q <= '0;
      hex_q     <= 1'b0;
      half_q    <= 1'b0;
      grp_q     <= '0;
      idx_q     <= '0;
      cur_q     <= '0;
      edit_q    <= '0;
      neg_q     <= 1'b0;
      res_q     <= RES_SAVED;
    end
    else
    begin
      if (in_mon && !ovr && p_up)
        mon_sel_q <= (mon_sel_q == MON_MAX) ? 5'h0 : mon_sel_q + 5'h1;
      else if (in_mon && !ovr && p_dn)
        mon_sel_q <= (mon_sel_q == 5'h0) ? MON_MAX : mon_sel_q - 5'h1;
      hex_q  <= hex_q ^ (in_mon && !ovr && p_set);
      half_q <= half_q ^ (in_mon && !ovr && p_sh);
      if (in_par && p_sh)
        grp_q <= (grp_q == GRP_MAX) ? 4'h0 : grp_q + 4'h1;
      if (in_par && p_up)
        idx_q <= (idx_q == IDX_MAX) ? 8'h0 : idx_q + 8'h1;
      else if (in_par && p_dn)
        idx_q <= (idx_q == 8'h0) ? IDX_MAX : idx_q - 8'h1;
      if (in_par && st_d == ST_SET)
      begin
        edit_q <= par_bcd;
        neg_q  <= par_neg;
        cur_q  <= '0;
      end
      else
      begin
        edit_q <= edit_nx;
        cur_q  <= (in_set && p_sh) ? (cur_q == CUR_MAX ? 3'h0 : cur_q + 3'h1) : cur_q;
        // Sign flip refused when the drive reports it would leave the range
        neg_q  <= neg_q ^ (hold_fire && par_sign_ok);
      end
      if (st_q == ST_WAIT && save_done)
        res_q <= save_result;
    end
  end

  // ----------------------------------------
  // Save and diagnosis strobes
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      save_req_q  <= 1'b0;
      diag_exec_q <= 1'b0;
      save_bcd_q  <= '0;
      save_neg_q  <= 1'b0;
    end
    else
    begin
      save_req_q  <= in_set && !ovr && p_set && !p_mode && !diag_active;
      diag_exec_q <= in_set && !ovr && p_set && !p_mode && diag_active;
      if (in_set && p_set)
      begin
        save_bcd_q <= edit_q;
        save_neg_q <= neg_q;
      end
    end
  end

  // ----------------------------------------
  // Display composition
  // ----------------------------------------
  logic [24:0] ch_d;
  logic [4:0]  dp_d, bl_d;
  wire [15:0]  hx_half = half_q ? val_bin[31:16] : val_bin[15:0];
  wire [19:0]  dc_half = half_q ? val_bcd[39:20] : val_bcd[19:0];
  wire [24:0]  sym_ch  = {CH_C, CH_DASH, CH_BLANK, hx({3'h0, mon_sel_q[4]}),
                          hx(mon_sel_q[3:0])};

  always_comb
  begin
    ch_d = {NDIG{CH_DASH}};
    dp_d = '0;
    bl_d = '0;
    case (st_q)
      ST_BOOT: ch_d = sym_ch;
      ST_MON:
      begin
        if (sym_q)
          ch_d = sym_ch;
        else if (hex_q)
          ch_d = {CH_BLANK, hx(hx_half[15:12]), hx(hx_half[11:8]),
                  hx(hx_half[7:4]), hx(hx_half[3:0])};
        else
        begin
          ch_d = {hx(dc_half[19:16]), hx(dc_half[15:12]), hx(dc_half[11:8]),
                  hx(dc_half[7:4]), hx(dc_half[3:0])};
          dp_d[DP_LOW]  = val_is32 && !half_q;
          dp_d[DP_HIGH] = val_is32 && half_q;
          dp_d[DP_NEG0] = val_neg;
          dp_d[DP_NEG1] = val_neg;
        end
      end
      ST_PAR: ch_d = {CH_P, hx(grp_q), CH_DASH, hx(idx_q[7:4]), hx(idx_q[3:0])};
      ST_SET:
      begin
        ch_d = {hx(edit_q[19:16]), hx(edit_q[15:12]), hx(edit_q[11:8]),
                hx(edit_q[7:4]), hx(edit_q[3:0])};
        bl_d[cur_q] = 1'b1;
        dp_d[DP_NEG0] = neg_q;
        dp_d[DP_NEG1] = neg_q;
      end
      ST_RES: ch_d = {CH_R, CH_DASH, CH_BLANK, CH_BLANK, hx({1'b0, res_q})};
      ST_FLT: ch_d = {CH_A, CH_L, hx(fault_code[11:8]), hx(fault_code[7:4]),
                      hx(fault_code[3:0])};
      default: ch_d = {NDIG{CH_DASH}};
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      disp_ch_q    <= {NDIG{CH_BLANK}};
      disp_dp_q    <= '0;
      disp_blink_q <= '0;
    end
    else
    begin
      disp_ch_q    <= ch_d;
      disp_dp_q    <= dp_d;
      disp_blink_q <= bl_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_boot_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_BOOT && tmr_done && !ovr |=> st_q == ST_MON)
    else $error("boot did not enter monitor");
  a_mode_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_mon && p_mode && !ovr |=> st_q == ST_PAR ##0 $past(st_q, 2) != ST_PAR)
    else $error("mode key did not reach parameters");
  a_alarm_fault: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(alarm_in) |=> st_q == ST_FLT)
    else $error("alarm did not force fault mode");
  a_fault_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_FLT && p_mode && !ovr |=> st_q == ST_MON)
    else $error("mode key did not leave fault");
  a_idle_return: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_hit |=> st_q == ST_FLT ##1 idle_q == 32'h0)
    else $error("idle alarm did not return to fault");
  a_set_enter: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_par && p_set && !p_mode && !ovr |=> in_set && edit_q == $past(par_bcd))
    else $error("setting mode not loaded");
  a_edit_discard: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_set && p_mode && !ovr |=> st_q == ST_PAR ##1 !save_req_q)
    else $error("discarded edit was saved");
  a_save_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
    save_req_q |-> $past(in_set && p_set) && save_bcd_q == $past(edit_q))
    else $error("save without set key");
  a_hex_toggle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    in_mon && p_set && !ovr |=> hex_q != $past(hex_q))
    else $error("set did not toggle radix");
  a_result_time: assert property (@(posedge clk_sys) disable iff (!rst_n)
    st_q == ST_WAIT && save_done && !ovr |=> st_q == ST_RES && tmr_q == P_SHOW - 1)
    else $error("result shown without full timer");
  a_press_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
    press[K_SET] |=> !press[K_SET] [*2])
    else $error("one press gave two events");
endmodule

// ---- test/key_operator.sv ----
`timescale 1ns/1ps
module key_operator
#(
  parameter int P_DB = 4
)(
  // Clock
  input  wire logic       clk_sys,
  // Keys, high while pressed
  output logic      [4:0] key_raw
);
  initial key_raw = 5'h00;

  // ----------------------------------------
  // One press, with contact bounce first
  // ----------------------------------------
  task automatic press(input int k, input int hold);
    @(posedge clk_sys);
    key_raw[k] <= 1'b1;
    @(posedge clk_sys);
    key_raw[k] <= 1'b0; // Bounce shorter than the filter
    @(posedge clk_sys);
    key_raw[k] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    key_raw[k] <= 1'b0;
    // Release must settle too, else the next press merges
    repeat (P_DB + 6) @(posedge clk_sys);
  endtask
endmodule

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import kpd_pkg::*;
;
  localparam int SHOW = 20;
  localparam int IDLE = 60;
  localparam int HOLD = 16;
  localparam int DB   = 4;
  localparam int PH   = DB + 6;

  logic        clk_sys;
  logic        rst_n;
  logic [4:0]  key_raw;
  logic        alarm_in;
  logic [11:0] fault_code;
  logic        diag_active;
  logic        val_neg;
  logic        val_is32;
  logic        par_neg;
  logic        par_sign_ok;
  logic        save_done;
  logic [2:0]  save_result;
  logic        save_req_q;
  logic [19:0] save_bcd_q;
  logic        save_neg_q;
  logic        diag_exec_q;
  mode_t       st_q;
  logic [4:0]  mon_sel_q;
  logic [3:0]  grp_q;
  logic [7:0]  idx_q;
  logic        hex_q;
  logic        half_q;
  logic [24:0] disp_ch_q;
  logic [4:0]  disp_dp_q;
  logic [4:0]  disp_blink_q;
  int          err_count = 0;
  int          checked = 0;
  int          req_cnt = 0;
  int          exec_cnt = 0;

  kpd_mode_ctrl #(.P_SHOW(SHOW), .P_IDLE(IDLE), .P_HOLD(HOLD), .P_DB(DB)) kpd_mode_ctrl_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .key_raw(key_raw), .alarm_in(alarm_in),
    .fault_code(fault_code), .diag_active(diag_active), .val_bin(32'h1234abcd),
    .val_bcd(40'h0000012345), .val_neg(val_neg), .val_is32(val_is32),
    .par_bcd(20'h12345), .par_neg(par_neg), .par_sign_ok(par_sign_ok),
    .save_done(save_done), .save_result(save_result), .save_req_q(save_req_q),
    .save_bcd_q(save_bcd_q), .save_neg_q(save_neg_q), .diag_exec_q(diag_exec_q),
    .st_q(st_q), .mon_sel_q(mon_sel_q), .grp_q(grp_q), .idx_q(idx_q), .hex_q(hex_q),
    .half_q(half_q), .disp_ch_q(disp_ch_q), .disp_dp_q(disp_dp_q),
    .disp_blink_q(disp_blink_q)
  );

  key_operator #(.P_DB(DB)) key_operator_i (
    .clk_sys(clk_sys),
    .key_raw(key_raw)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // Pulses last one cycle, so count them at every edge
  always @(posedge clk_sys)
  begin
    req_cnt  <= req_cnt + int'(save_req_q === 1'b1);
    exec_cnt <= exec_cnt + int'(diag_exec_q === 1'b1);
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic key(input int k);
    key_operator_i.press(k, PH);
  endtask

  task automatic respond(input logic [2:0] r);
    @(posedge clk_sys);
    save_done   <= 1'b1;
    save_result <= r;
    @(posedge clk_sys);
    save_done   <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(st_q, ST_RES);
    chk(disp_ch_q[24:20], CH_R);
    chk(disp_ch_q[4:0], {2'h0, r});
    repeat (SHOW + 2) @(posedge clk_sys);
    chk(st_q, ST_PAR);
  endtask

  task automatic summarize();
    $display("checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_boot();
    repeat (3) @(posedge clk_sys);
    chk(st_q, ST_BOOT);
    chk(disp_ch_q, {CH_C, CH_DASH, CH_BLANK, 5'h00, 5'h00});
    repeat (SHOW + 2) @(posedge clk_sys);
    chk(st_q, ST_MON);
    $display("test boot done");
  endtask

  task automatic t_monitor();
    key(K_UP);
    chk(mon_sel_q, 5'h01);
    chk(disp_ch_q[24:15], {CH_C, CH_DASH});
    chk(disp_ch_q[4:0], 5'h01);
    key(K_DOWN);
    key(K_DOWN);
    chk(mon_sel_q, MON_MAX);
    repeat (SHOW + 2) @(posedge clk_sys);
    chk(disp_dp_q[DP_NEG1:DP_NEG0], 2'h3);
    chk(disp_dp_q[DP_HIGH:DP_LOW], 2'h1);
    chk(disp_ch_q, {5'h01, 5'h02, 5'h03, 5'h04, 5'h05});
    key(K_SHIFT);
    chk(disp_dp_q[DP_HIGH:DP_LOW], 2'h2);
    key(K_SET);
    chk(hex_q, 1'b1);
    chk(disp_ch_q, {CH_BLANK, 5'h01, 5'h02, 5'h03, 5'h04});
    chk(disp_dp_q[DP_NEG1:DP_NEG0], 2'h0);
    key(K_SET);
    chk(hex_q, 1'b0);
    $display("test monitor done");
  endtask

  task automatic t_param();
    key(K_MODE);
    chk(st_q, ST_PAR);
    key(K_SHIFT);
    chk(grp_q, 4'h1);
    key(K_DOWN);
    chk(idx_q, IDX_MAX);
    key(K_UP);
    chk(idx_q, 8'h00);
    chk(disp_ch_q, {CH_P, 5'h01, CH_DASH, 5'h00, 5'h00});
    key(K_SET);
    chk(st_q, ST_SET);
    chk(disp_ch_q, {5'h01, 5'h02, 5'h03, 5'h04, 5'h05});
    key(K_MODE);
    chk(st_q, ST_PAR);
    chk(req_cnt, 0);
    key(K_MODE);
    chk(st_q, ST_MON);
    key(K_MODE);
    $display("test param done");
  endtask

  task automatic t_save();
    int n0;
    for (int r = 0; r < 6; r++)
    begin
      n0 = req_cnt;
      key(K_SET);
      chk(disp_blink_q, 5'h01);
      key(K_SHIFT);
      chk(disp_blink_q, 5'h02);
      key(K_UP);
      chk(disp_ch_q[9:5], 5'h05);
      chk(req_cnt, n0);
      key(K_SET);
      chk(req_cnt, n0 + 1);
      chk(save_bcd_q, 20'h12355);
      chk(st_q, ST_WAIT);
      respond(r[2:0]);
    end
    $display("test save done");
  endtask

  task automatic t_diag_sign();
    key(K_SET);
    diag_active <= 1'b1;
    key(K_SET);
    chk(exec_cnt, 1);
    chk(st_q, ST_SET);
    diag_active <= 1'b0;
    key(K_MODE);
    // Out-of-range flip must leave the sign alone
    for (int ok = 1; ok >= 0; ok--)
    begin
      par_sign_ok <= ok[0];
      key(K_SET);
      key_operator_i.press(K_SHIFT, HOLD + PH);
      key(K_SET);
      chk(save_neg_q, ok[0]);
      respond(RES_SAVED);
    end
    $display("test diag and sign done");
  endtask

  task automatic t_fault();
    @(posedge clk_sys);
    alarm_in <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk(st_q, ST_FLT);
    @(posedge clk_sys);
    chk(disp_ch_q, {CH_A, CH_L, 5'h03, 5'h00, 5'h07});
    key(K_MODE);
    chk(st_q, ST_MON);
    repeat (IDLE / 2) @(posedge clk_sys);
    chk(st_q, ST_MON);
    repeat (IDLE) @(posedge clk_sys);
    chk(st_q, ST_FLT);
    alarm_in <= 1'b0;
    key(K_MODE);
    chk(st_q, ST_MON);
    $display("test fault done");
  endtask

  // Mid-run reset must clear selections and restart the boot display
  task automatic t_reset();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(st_q, ST_BOOT);
    chk(mon_sel_q, 5'h00);
    chk(disp_ch_q, {NDIG{CH_BLANK}});
    rst_n <= 1'b1;
    t_boot();
    $display("test reset done");
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    rst_n       = 1'b0;
    alarm_in    = 1'b0;
    fault_code  = 12'h307;
    diag_active = 1'b0;
    val_neg     = 1'b1;
    val_is32    = 1'b1;
    par_neg     = 1'b0;
    par_sign_ok = 1'b1;
    save_done   = 1'b0;
    save_result = 3'h0;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_boot();
    t_monitor();
    t_param();
    t_save();
    t_diag_sign();
    t_fault();
    t_reset();
    summarize();
  end

  // Roughly 1550 cycles of tests; generous margin
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    summarize();
  end
endmodule
